// file: common/dttc_regs.vh
/*
  Register map, field positions, reset values and timing counts of the
  per-channel DRAM thermal throttle control.
  Assumes inclusion by the design files of that block only.
*/
`ifndef DTTC_REGS_VH
`define DTTC_REGS_VH

// Register offsets
`define DTTC_CTRL_OFF      8'h48
`define DTTC_STAT_OFF      8'h4C
`define DTTC_LOCK_OFF      8'h50
`define DTTC_WGT_OFF       8'h60
`define DTTC_SAFE_OFF      8'h64
`define DTTC_COOL_OFF      8'h80

// Control fields
`define DTTC_MODE_MSB      1
`define DTTC_MODE_LSB      0
`define DTTC_SAFE_EN_BIT   2
`define DTTC_CTRL_RST      3'h4

// Throttle modes
`define DTTC_MODE_OFF      2'h0
`define DTTC_MODE_OPEN     2'h1
`define DTTC_MODE_FORCE    2'h2
`define DTTC_MODE_PIN      2'h3

// Status fields
`define DTTC_CNT_MSB       29
`define DTTC_CNT_LSB       4
`define DTTC_CNT_W         26
`define DTTC_CNT_UNIT      9'h100

// Energy weight fields
`define DTTC_W_CKE_ON_MSB  31
`define DTTC_W_CKE_ON_LSB  24
`define DTTC_W_CKE_OFF_MSB 23
`define DTTC_W_CKE_OFF_LSB 16
`define DTTC_W_WR_MSB      15
`define DTTC_W_WR_LSB      8
`define DTTC_W_RD_MSB      7
`define DTTC_W_RD_LSB      0
`define DTTC_WGT_RST       32'h00000000

// Fallback parameter fields
`define DTTC_WIN_MSB       31
`define DTTC_WIN_LSB       26
`define DTTC_FDUTY_MSB     25
`define DTTC_FDUTY_LSB     16
`define DTTC_FCOOL_MSB     15
`define DTTC_FCOOL_LSB     8
`define DTTC_W_ACT_MSB     7
`define DTTC_W_ACT_LSB     0
`define DTTC_SAFE_RST      32'h04FF0100
`define DTTC_COOL_RST      32'hFFFFFFFF

// Estimate sizing and last cooling divider count; cooling period of 8 DRAM clocks
`define DTTC_TEMP_W        24
`define DTTC_COOL_PERIOD   3'h7

`endif

// file: hdl/dttc_rank_temp.v
/*
  Virtual temperature estimate of one DRAM rank: adds command and idle
  energy each clock, removes the cooling weight once per cooling period.
  Assumes command strobes and weights arrive on mclk.
*/
`timescale 1ns/100ps
`include "dttc_regs.vh"

module dttc_rank_temp (
  // Clock and reset
  input  wire                     mclk,
  input  wire                     rst_n,
  // Rank activity
  input  wire                     cmd_rd,
  input  wire                     cmd_wr,
  input  wire                     cmd_act,
  input  wire                     cke_on,
  // Weights
  input  wire [7:0]               read_weight,
  input  wire [7:0]               write_weight,
  input  wire [7:0]               act_weight,
  input  wire [7:0]               idle_clock_on_weight,
  input  wire [7:0]               idle_clock_off_weight,
  input  wire [7:0]               cooling_weight,
  input  wire                     cool_tick,
  // Estimate
  output reg  [`DTTC_TEMP_W-1:0]  vtemp_q
);

  reg  [7:0]              energy;
  reg  [`DTTC_TEMP_W:0]   sum;
  reg  [`DTTC_TEMP_W:0]   vtemp_d;

  always @* begin
    if (cmd_rd)
      energy = read_weight;
    else if (cmd_wr)
      energy = write_weight;
    else if (cmd_act)
      energy = act_weight;
    else if (cke_on)
      energy = idle_clock_on_weight;
    else
      energy = idle_clock_off_weight;
    sum = {1'b0, vtemp_q} + {{(`DTTC_TEMP_W-7){1'b0}}, energy};
    if (cool_tick)
      vtemp_d = (sum > {{(`DTTC_TEMP_W-7){1'b0}}, cooling_weight}) ?
                sum - {{(`DTTC_TEMP_W-7){1'b0}}, cooling_weight} :
                {(`DTTC_TEMP_W+1){1'b0}};
    else
      vtemp_d = sum;
    if (vtemp_d[`DTTC_TEMP_W])
      vtemp_d = {1'b0, {`DTTC_TEMP_W{1'b1}}};
  end

  always @(posedge mclk) begin
    if (!rst_n)
      vtemp_q <= {`DTTC_TEMP_W{1'b0}};
    else
      vtemp_q <= vtemp_d[`DTTC_TEMP_W-1:0];
  end

endmodule // dttc_rank_temp

// file: hdl/dttc_channel.v
/*
  Thermal throttle control of one DRAM channel: registers, throttle mode
  selection, fallback safe values, throttled cycle count and rank flags.
  Assumes one instance per channel, all inputs except external_hot_pin on
  mclk, and a register port driven by the controller's configuration logic.
*/
`timescale 1ns/100ps
`include "dttc_regs.vh"

module dttc_channel (
  // Clock and reset
  input  wire         mclk,
  input  wire         rst_n,
  // Register port
  input  wire [7:0]   cfg_addr,
  input  wire         cfg_wr_en,
  input  wire [31:0]  cfg_wdata,
  input  wire         cfg_rd_en,
  output reg  [31:0]  cfg_rdata_q,
  // Closed-loop register held outside
  input  wire         closed_loop_wr,
  input  wire         force_throttle,
  input  wire [9:0]   min_duty,
  input  wire [23:0]  open_loop_threshold,
  input  wire         pin_throttle_enable,
  // Rank activity
  input  wire [3:0]   rank_rd,
  input  wire [3:0]   rank_wr,
  input  wire [3:0]   rank_act,
  input  wire [3:0]   rank_cke,
  input  wire         zq_tick,
  // Pin
  input  wire         external_hot_pin,
  // Throttle outputs
  output reg          throttle_q,
  output reg          fallback_active_q,
  output reg  [31:0]  eff_cooling_q,
  output reg  [9:0]   eff_min_duty_q,
  output wire         thermal_settings_lock
);

  reg  [2:0]                ctrl_q;
  reg                       lock_q;
  reg  [31:0]               wgt_q;
  reg  [31:0]               safe_q;
  reg  [31:0]               cool_q;
  reg  [3:0]                hot_q;
  reg  [`DTTC_CNT_W-1:0]    cnt_q;
  reg  [7:0]                sub_q;
  reg  [5:0]                fb_zq_q;
  reg  [5:0]                st_zq_q;
  reg  [2:0]                cool_div_q;
  reg                       pin_s1_q;
  reg                       pin_s2_q;
  reg                       throttle_d;
  wire                      wr_ok;
  wire                      cool_tick;
  wire [5:0]                window;
  wire                      fallback;
  wire [`DTTC_TEMP_W*4-1:0] vtemp;
  wire                      any_hot;
  wire [1:0]                mode;

  function sel;
    input [7:0] addr;
    input [7:0] off;
    begin
      sel = (addr == off);
    end
  endfunction

  assign wr_ok                 = cfg_wr_en & ~lock_q;
  assign thermal_settings_lock = lock_q;
  assign window                = safe_q[`DTTC_WIN_MSB:`DTTC_WIN_LSB];
  assign fallback              = fb_zq_q > window;
  assign cool_tick             = (cool_div_q == `DTTC_COOL_PERIOD);
  assign any_hot               = |hot_q;
  assign mode                  = ctrl_q[`DTTC_MODE_MSB:`DTTC_MODE_LSB];

  // Registers
  always @(posedge mclk) begin
    if (!rst_n) begin
      ctrl_q <= `DTTC_CTRL_RST;
      lock_q <= 1'b0;
      wgt_q  <= `DTTC_WGT_RST;
      safe_q <= `DTTC_SAFE_RST;
      cool_q <= `DTTC_COOL_RST;
    end else begin
      if (cfg_wr_en && sel(cfg_addr, `DTTC_LOCK_OFF) && cfg_wdata[0])
        lock_q <= 1'b1;
      if (wr_ok && sel(cfg_addr, `DTTC_CTRL_OFF))
        ctrl_q <= cfg_wdata[2:0];
      if (wr_ok && sel(cfg_addr, `DTTC_WGT_OFF))
        wgt_q <= cfg_wdata;
      if (wr_ok && sel(cfg_addr, `DTTC_SAFE_OFF))
        safe_q <= cfg_wdata;
      if (wr_ok && sel(cfg_addr, `DTTC_COOL_OFF))
        cool_q <= cfg_wdata;
    end
  end

  // Read data
  always @(posedge mclk) begin
    if (!rst_n) begin
      cfg_rdata_q <= 32'h00000000;
    end else if (cfg_rd_en) begin
      case (1'b1)
        sel(cfg_addr, `DTTC_CTRL_OFF): cfg_rdata_q <= {29'h00000000, ctrl_q};
        sel(cfg_addr, `DTTC_STAT_OFF): cfg_rdata_q <= {2'h0, cnt_q, hot_q};
        sel(cfg_addr, `DTTC_LOCK_OFF): cfg_rdata_q <= {31'h00000000, lock_q};
        sel(cfg_addr, `DTTC_WGT_OFF):  cfg_rdata_q <= wgt_q;
        sel(cfg_addr, `DTTC_SAFE_OFF): cfg_rdata_q <= safe_q;
        sel(cfg_addr, `DTTC_COOL_OFF): cfg_rdata_q <= cool_q;
        default:                       cfg_rdata_q <= 32'h00000000;
      endcase
    end
  end

  // Pin synchroniser
  always @(posedge mclk) begin
    if (!rst_n) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
    end else begin
      pin_s1_q <= external_hot_pin;
      pin_s2_q <= pin_s1_q;
    end
  end

  // Rank estimates
  genvar r;
  generate
    for (r = 0; r < 4; r = r + 1) begin : g_rank
      dttc_rank_temp u_temp (
        .mclk                  (mclk),
        .rst_n                 (rst_n),
        .cmd_rd                (rank_rd[r]),
        .cmd_wr                (rank_wr[r]),
        .cmd_act               (rank_act[r]),
        .cke_on                (rank_cke[r]),
        .read_weight           (wgt_q[`DTTC_W_RD_MSB:`DTTC_W_RD_LSB]),
        .write_weight          (wgt_q[`DTTC_W_WR_MSB:`DTTC_W_WR_LSB]),
        .act_weight            (safe_q[`DTTC_W_ACT_MSB:`DTTC_W_ACT_LSB]),
        .idle_clock_on_weight  (wgt_q[`DTTC_W_CKE_ON_MSB:`DTTC_W_CKE_ON_LSB]),
        .idle_clock_off_weight (wgt_q[`DTTC_W_CKE_OFF_MSB:`DTTC_W_CKE_OFF_LSB]),
        .cooling_weight        (eff_cooling_q[r*8+7:r*8]),
        .cool_tick             (cool_tick),
        .vtemp_q               (vtemp[r*`DTTC_TEMP_W+`DTTC_TEMP_W-1:r*`DTTC_TEMP_W])
      );
    end
  endgenerate

  // Throttle decision
  always @* begin
    case (mode)
      `DTTC_MODE_OFF:   throttle_d = 1'b0;
      `DTTC_MODE_OPEN:  throttle_d = any_hot;
      `DTTC_MODE_FORCE: throttle_d = force_throttle;
      `DTTC_MODE_PIN:   throttle_d = (pin_throttle_enable & pin_s2_q) | any_hot;
      default:          throttle_d = 1'b0;
    endcase
  end

  // Status, windows and substitution
  integer k;
  always @(posedge mclk) begin
    if (!rst_n) begin
      hot_q             <= 4'h0;
      cnt_q             <= {`DTTC_CNT_W{1'b0}};
      sub_q             <= 8'h00;
      fb_zq_q           <= 6'h00;
      st_zq_q           <= 6'h00;
      cool_div_q        <= 3'h0;
      throttle_q        <= 1'b0;
      fallback_active_q <= 1'b0;
      eff_cooling_q     <= `DTTC_COOL_RST;
      eff_min_duty_q    <= 10'h000;
    end else begin
      cool_div_q <= cool_div_q + 3'h1;
      for (k = 0; k < 4; k = k + 1)
        hot_q[k] <= vtemp[k*`DTTC_TEMP_W +: `DTTC_TEMP_W] > open_loop_threshold;
      throttle_q <= throttle_d;
      if ((wr_ok && sel(cfg_addr, `DTTC_COOL_OFF)) || (closed_loop_wr && !lock_q))
        fb_zq_q <= 6'h00;
      else if (zq_tick && fb_zq_q != 6'h3F)
        fb_zq_q <= fb_zq_q + 6'h01;
      if (zq_tick && st_zq_q >= window) begin
        st_zq_q <= 6'h00;
        cnt_q   <= {`DTTC_CNT_W{1'b0}};
        sub_q   <= 8'h00;
      end else begin
        if (zq_tick)
          st_zq_q <= st_zq_q + 6'h01;
        if (throttle_q) begin
          sub_q <= sub_q + 8'h01;
          if (sub_q == 8'hFF && cnt_q != {`DTTC_CNT_W{1'b1}})
            cnt_q <= cnt_q + {{(`DTTC_CNT_W-1){1'b0}}, 1'b1};
        end
      end
      fallback_active_q <= fallback & ctrl_q[`DTTC_SAFE_EN_BIT];
      if (fallback && ctrl_q[`DTTC_SAFE_EN_BIT]) begin
        eff_cooling_q  <= {4{safe_q[`DTTC_FCOOL_MSB:`DTTC_FCOOL_LSB]}};
        eff_min_duty_q <= safe_q[`DTTC_FDUTY_MSB:`DTTC_FDUTY_LSB];
      end else begin
        eff_cooling_q  <= cool_q;
        eff_min_duty_q <= min_duty;
      end
    end
  end

endmodule // dttc_channel

// file: tb/dttc_monitor.sv
/* Checker of the channel register port and throttle outputs.
   Assumes the ports of dttc_channel only; bound after the module. */
`timescale 1ns/100ps
module dttc_monitor (
  // Clock, reset and register port
  input wire        mclk,
  input wire        rst_n,
  input wire [7:0]  cfg_addr,
  input wire        cfg_wr_en,
  input wire [31:0] cfg_wdata,
  input wire        cfg_rd_en,
  input wire [31:0] cfg_rdata_q,
  // Throttle
  input wire        force_throttle,
  input wire [9:0]  min_duty,
  input wire        throttle_q,
  input wire        fallback_active_q,
  input wire [9:0]  eff_min_duty_q,
  input wire        thermal_settings_lock
);
  reg [2:0] ctrl_q;
  always @(posedge mclk) begin
    if (!rst_n)
      ctrl_q <= 3'h4;
    else if (cfg_wr_en && cfg_addr == 8'h48 && !thermal_settings_lock)
      ctrl_q <= cfg_wdata[2:0];
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_mode_off_idle: assert property (ctrl_q[1:0] == 2'h0 |=> !throttle_q)
    else $error("throttle in mode 0");
  a_force_mode_on: assert property (ctrl_q[1:0] == 2'h2 && force_throttle |=> throttle_q)
    else $error("no throttle on force");
  a_force_mode_off: assert property (ctrl_q[1:0] == 2'h2 && !force_throttle |=> !throttle_q)
    else $error("throttle without force");
  a_safe_gate: assert property (!ctrl_q[2] |=> !fallback_active_q)
    else $error("fallback while safe disabled");
  a_duty_pass: assert property ($past(rst_n) && !fallback_active_q |->
    eff_min_duty_q == $past(min_duty)) else $error("duty not passed through");
  a_lock_sticky: assert property (thermal_settings_lock |=> thermal_settings_lock)
    else $error("lock cleared");
  a_lock_set: assert property (cfg_wr_en && cfg_addr == 8'h50 && cfg_wdata[0]
    |=> thermal_settings_lock) else $error("lock not set");
  a_ctrl_read: assert property (cfg_rd_en && cfg_addr == 8'h48 |=>
    cfg_rdata_q == {29'h0, $past(ctrl_q)}) else $error("control read wrong");
  a_stat_upper: assert property (cfg_rd_en && cfg_addr == 8'h4C |=>
    cfg_rdata_q[31:30] == 2'h0) else $error("status top bits set");
endmodule // dttc_monitor

bind dttc_channel dttc_monitor i_dttc_monitor (.mclk, .rst_n, .cfg_addr, .cfg_wr_en,
  .cfg_wdata, .cfg_rd_en, .cfg_rdata_q, .force_throttle, .min_duty, .throttle_q,
  .fallback_active_q, .eff_min_duty_q, .thermal_settings_lock);

// file: tb/dttc_rank_model.sv
/* Ranks of one channel: reads and writes on all ranks while traffic is on,
   clock enable dropped on request, and one ZQ interval pulse per request.
   Assumes requests on mclk. */
`timescale 1ns/100ps
module dttc_rank_model (
  // Clock and bench control
  input  wire       mclk,
  input  wire       traffic,
  input  wire       zq_req,
  input  wire       cke_off,
  // Rank activity
  output reg  [3:0] rank_rd = 4'h0,
  output reg  [3:0] rank_wr = 4'h0,
  output reg  [3:0] rank_act = 4'h0,
  output reg  [3:0] rank_cke = 4'hF,
  output reg        zq_tick = 1'b0
);
  reg ph_q = 1'b0;
  always @(posedge mclk) begin
    ph_q <= ~ph_q;
    rank_rd <= {4{traffic & ph_q}};
    rank_wr <= {4{traffic & ~ph_q}};
    rank_act <= 4'h0;
    rank_cke <= {4{~cke_off}};
    zq_tick <= zq_req;
  end
endmodule // dttc_rank_model

// file: tb/dttc_channel_tb.sv
/* Self-checking bench of dttc_channel with the rank model at its far side.
   Assumes a 10 MHz mclk and the register map reset values. */
`timescale 1ns/100ps
module dttc_channel_tb;
  reg         mclk = 1'b0, rst_n = 1'b0, cfg_wr_en = 1'b0, cfg_rd_en = 1'b0;
  reg  [7:0]  cfg_addr = 8'h00;
  reg  [31:0] cfg_wdata = 32'h0;
  reg         force_throttle = 1'b0, pin_throttle_enable = 1'b0, external_hot_pin = 1'b0;
  reg  [9:0]  min_duty = 10'h000;
  reg  [23:0] open_loop_threshold = 24'h000100;
  reg         traffic = 1'b0, zq_req = 1'b0, rd_pend = 1'b0;
  reg         closed_loop_wr = 1'b0, cke_off = 1'b0;
  wire [31:0] cfg_rdata_q, eff_cooling_q;
  wire [9:0]  eff_min_duty_q;
  wire [3:0]  rank_rd, rank_wr, rank_act, rank_cke;
  wire        zq_tick, throttle_q, fallback_active_q, thermal_settings_lock;
  logic [31:0] exp_q[$];
  logic [31:0] w;
  logic [7:0]  adr_t[7] = '{8'h48, 8'h4C, 8'h50, 8'h60, 8'h64, 8'h80, 8'h44};
  logic [31:0] rst_t[7] = '{32'h4, 32'h0, 32'h0, 32'h0, 32'h04FF0100, 32'hFFFFFFFF, 32'h0};
  integer     failures = 0, total_checks = 0, cyc = 0, seed = 2, i;
  always #50 mclk = ~mclk;
  dttc_channel i_dttc_channel (.mclk, .rst_n, .cfg_addr, .cfg_wr_en, .cfg_wdata,
    .cfg_rd_en, .cfg_rdata_q, .closed_loop_wr, .force_throttle, .min_duty,
    .open_loop_threshold, .pin_throttle_enable, .rank_rd, .rank_wr, .rank_act,
    .rank_cke, .zq_tick, .external_hot_pin, .throttle_q, .fallback_active_q,
    .eff_cooling_q, .eff_min_duty_q, .thermal_settings_lock);
  dttc_rank_model i_dttc_rank_model (.mclk, .traffic, .zq_req, .cke_off, .rank_rd, .rank_wr,
    .rank_act, .rank_cke, .zq_tick);
  task give_verdict;
    begin
      $display("Checks %0d, mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    begin
      total_checks++;
      if (s !== e) begin
        failures++;
        $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge mclk);
      cfg_addr <= a;
      cfg_wdata <= d;
      cfg_wr_en <= 1'b1;
      @(posedge mclk);
      cfg_wr_en <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      @(posedge mclk);
      cfg_addr <= a;
      cfg_rd_en <= 1'b1;
      exp_q.push_back(e);
      @(posedge mclk);
      cfg_rd_en <= 1'b0;
    end
  endtask
  task zq(input integer n);
    repeat (n) begin
      @(posedge mclk);
      zq_req <= 1'b1;
      @(posedge mclk);
      zq_req <= 1'b0;
    end
  endtask
  task clw;
    begin
      @(posedge mclk);
      closed_loop_wr <= 1'b1;
      @(posedge mclk);
      closed_loop_wr <= 1'b0;
    end
  endtask
  task thr(input logic e);
    begin
      repeat (6) @(posedge mclk);
      chk("throttle", {31'h0, e}, {31'h0, throttle_q});
    end
  endtask
  // Read results are compared with the oldest noted expectation
  always @(posedge mclk) begin
    if (rd_pend)
      chk("rdata", exp_q.pop_front(), cfg_rdata_q);
    rd_pend <= cfg_rd_en;
    cyc++;
    if (cyc == 5000) begin
      failures++;
      give_verdict;
    end
  end
  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    for (i = 0; i < 7; i++) rd(adr_t[i], rst_t[i]);
    for (i = 0; i < 4; i++) begin
      wr(8'h48, 32'h4 | i);
      rd(8'h48, 32'h4 | i);
    end
    w = $random(seed);
    wr(8'h60, w);
    rd(8'h60, w);
    wr(8'h60, 32'h10104040);
    wr(8'h48, 32'h5);
    traffic <= 1'b1;
    i = 0;
    while (throttle_q !== 1'b1 && i < 200) begin
      @(posedge mclk);
      i++;
    end
    chk("throttle", 32'h1, {31'h0, throttle_q});
    repeat (600) @(posedge mclk);
    rd(8'h4C, 32'h2F);
    traffic <= 1'b0;
    wr(8'h48, 32'h6);
    force_throttle <= 1'b1;
    thr(1'b1);
    force_throttle <= 1'b0;
    thr(1'b0);
    wr(8'h48, 32'h4);
    force_throttle <= 1'b1;
    thr(1'b0);
    force_throttle <= 1'b0;
    open_loop_threshold <= 24'hFFFFFF;
    wr(8'h48, 32'h7);
    pin_throttle_enable <= 1'b1;
    external_hot_pin <= 1'b1;
    thr(1'b1);
    pin_throttle_enable <= 1'b0;
    thr(1'b0);
    external_hot_pin <= 1'b0;
    w = $random(seed);
    min_duty <= w[9:0];
    wr(8'h64, 32'h04FF0100);
    zq(2);
    rd(8'h4C, 32'h0);
    thr(1'b0);
    chk("fallback", 32'h1, {31'h0, fallback_active_q});
    chk("duty", 32'hFF, {22'h0, eff_min_duty_q});
    chk("cooling", 32'h01010101, eff_cooling_q);
    wr(8'h80, 32'hC0C0C0C0);
    thr(1'b0);
    chk("fallback", 32'h0, {31'h0, fallback_active_q});
    chk("duty", {22'h0, w[9:0]}, {22'h0, eff_min_duty_q});
    chk("cooling", 32'hC0C0C0C0, eff_cooling_q);
    wr(8'h48, 32'h0);
    zq(3);
    thr(1'b0);
    chk("fallback", 32'h0, {31'h0, fallback_active_q});
    chk("cooling", 32'hC0C0C0C0, eff_cooling_q);
    wr(8'h48, 32'h4);
    thr(1'b0);
    chk("fallback", 32'h1, {31'h0, fallback_active_q});
    clw;
    thr(1'b0);
    chk("fallback", 32'h0, {31'h0, fallback_active_q});
    zq(2);
    wr(8'h50, 32'h1);
    clw;
    chk("lock", 32'h1, {31'h0, thermal_settings_lock});
    wr(8'h80, 32'h11111111);
    wr(8'h60, $random(seed));
    thr(1'b0);
    chk("fallback", 32'h1, {31'h0, fallback_active_q});
    chk("cooling", 32'h01010101, eff_cooling_q);
    rd(8'h60, 32'h10104040);
    wr(8'h50, 32'h0);
    rd(8'h50, 32'h1);
    repeat (2) @(posedge mclk);
    rst_n <= 1'b0;
    open_loop_threshold <= 24'h000100;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    rd(8'h50, 32'h0);
    rd(8'h4C, 32'h0);
    wr(8'h60, 32'h00800000);
    wr(8'h48, 32'h1);
    thr(1'b0);
    cke_off <= 1'b1;
    repeat (10) @(posedge mclk);
    thr(1'b1);
    wr(8'h48, 32'h3);
    thr(1'b1);
    cke_off <= 1'b0;
    repeat (3) @(posedge mclk);
    give_verdict;
  end
endmodule // dttc_channel_tb
